// >>> hw/gsz_ctrl.sv
/*
 * Gas sensor mode, filter and zero-point control with UART reply path and APB registers.
 * Assumes sensor_raw comes from front-end logic on pclk and nonvolatile storage outside.
 */
`timescale 1ns/1ns
`default_nettype none

module gsz_ctrl #(
	parameter int MEAS_PERIOD = gsz_pkg::MEAS_CYC,
	parameter int MEAS_BUSY = gsz_pkg::POSTPONE_CYC,
	parameter logic [15:0] FULL_SCALE = gsz_pkg::FULL_PPM
)(
	input wire logic pclk, // clock
	input wire logic presetn, // async reset
	input wire logic pclk_en, // freezes all state when low
	input wire gsz_pkg::gsz_apb_t apb, // APB request
	output logic [31:0] prdata, // read data
	output logic pready, // transfer done
	output logic pslverr, // unmapped address
	input wire logic [15:0] sensor_raw, // uncorrected reading
	input wire gsz_pkg::gsz_nv_t nv_in, // stored settings
	output gsz_pkg::gsz_nv_t nv_out, // settings to store
	input wire logic rx_pin, // serial in
	output logic tx_pin, // serial out
	output logic ready, // interface active
	output logic [15:0] conc_out, // filtered reading
	output logic [15:0] raw_out // unfiltered reading
);

	gsz_pkg::gsz_state_t s;
	gsz_pkg::gsz_state_t next_s;
	logic setup;
	logic access;
	logic wr;
	logic meas_now;
	logic go;
	logic [3:0] exec;
	logic [15:0] conc_new;
	logic signed [16:0] diff;
	logic [15:0] p;
	logic [15:0] dg;
	logic [7:0] ch;
	logic [31:0] stat;
	localparam logic [17:0] BUSY_W = 18'(MEAS_BUSY);

	function automatic logic [15:0] gsz_pow10(input logic [2:0] i);
		case (i)
			3'h1: gsz_pow10 = 16'h2710;
			3'h2: gsz_pow10 = 16'h03e8;
			3'h3: gsz_pow10 = 16'h0064;
			3'h4: gsz_pow10 = 16'h000a;
			default: gsz_pow10 = 16'h0001;
		endcase
	endfunction

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign tx_pin = s.tx;
	assign ready = s.loaded;
	assign nv_out = {s.loaded, s.nv_mode, s.zero, s.fresh};
	assign conc_out = s.filt;
	assign raw_out = s.conc;

	always_comb
	begin
		setup = apb.psel && !apb.penable;
		access = apb.psel && apb.penable && s.pready;
		wr = access && apb.pwrite;
		meas_now = (s.tick == 24'(MEAS_PERIOD - 1));
		conc_new = sensor_raw - s.zero;
		diff = $signed({1'b0, conc_new}) - $signed({1'b0, s.filt});
		go = (s.pend != 4'h0) && (s.busy == 18'h0) && (s.mode != gsz_pkg::M_CMD) && s.loaded && !meas_now;
		exec = go ? (s.pend & (~s.pend + 4'h1)) : 4'h0;
		p = gsz_pow10(s.idx);
		dg = s.val / p;
		case (s.idx)
			3'h0: ch = gsz_pkg::CH_SP;
			3'h6: ch = gsz_pkg::CH_CR;
			3'h7: ch = gsz_pkg::CH_LF;
			default: ch = s.qmark ? gsz_pkg::CH_QM : 8'(gsz_pkg::CH_0 + dg[7:0]);
		endcase
		stat = 32'h0;
		stat[gsz_pkg::S_READY] = s.loaded;
		stat[gsz_pkg::S_REFUSED] = s.refused;
		stat[gsz_pkg::S_BUSY] = (s.busy != 18'h0);
		stat[gsz_pkg::S_RXB +: 8] = s.rx_last;
	end

	always_comb
	begin
		next_s = s;

		if (!s.loaded)
		begin
			next_s.loaded = 1'b1;
			if (nv_in.valid)
			begin
				next_s.mode = (nv_in.mode == gsz_pkg::M_POLL) ? gsz_pkg::M_POLL : gsz_pkg::M_STREAM;
				next_s.zero = nv_in.zero;
				next_s.fresh = nv_in.fresh;
			end
			else
			begin
				next_s.mode = gsz_pkg::M_STREAM;
				next_s.fresh = gsz_pkg::FRESH_RST;
			end
			next_s.nv_mode = next_s.mode;
		end

		next_s.tick = meas_now ? 24'h0 : s.tick + 24'h1;
		if (s.busy != 18'h0)
			next_s.busy = s.busy - 18'h1;
		if (meas_now && s.loaded && s.mode != gsz_pkg::M_CMD)
		begin
			next_s.conc = conc_new;
			next_s.filt = s.filt + 16'(diff >>> s.filt_k);
			next_s.busy = BUSY_W;
		end

		if (exec[gsz_pkg::K_KNOWN])
			next_s.zero = sensor_raw - s.known;
		if (exec[gsz_pkg::K_N2])
			next_s.zero = sensor_raw;
		if (exec[gsz_pkg::K_FRESH])
			next_s.zero = sensor_raw - s.fresh;
		if (exec[gsz_pkg::K_FINE])
			next_s.zero = s.zero + s.frep - s.ftrue;
		next_s.pend = s.pend & ~exec;
		if (s.mode == gsz_pkg::M_CMD)
			next_s.pend = 4'h0;

		next_s.pready = setup;
		if (setup)
		begin
			next_s.pslverr = 1'b0;
			if (apb.paddr == gsz_pkg::A_CTRL)
				next_s.prdata = {27'h0, s.filt_k, s.mode};
			else if (apb.paddr == gsz_pkg::A_CMD)
				next_s.prdata = {28'h0, s.pend};
			else if (apb.paddr == gsz_pkg::A_KNOWN)
				next_s.prdata = {16'h0, s.known};
			else if (apb.paddr == gsz_pkg::A_FRESH)
				next_s.prdata = {16'h0, s.fresh};
			else if (apb.paddr == gsz_pkg::A_FTRUE)
				next_s.prdata = {16'h0, s.ftrue};
			else if (apb.paddr == gsz_pkg::A_FREP)
				next_s.prdata = {16'h0, s.frep};
			else if (apb.paddr == gsz_pkg::A_ZERO)
				next_s.prdata = {16'h0, s.zero};
			else if (apb.paddr == gsz_pkg::A_FILT)
				next_s.prdata = {16'h0, s.filt};
			else if (apb.paddr == gsz_pkg::A_RAW)
				next_s.prdata = {16'h0, s.conc};
			else if (apb.paddr == gsz_pkg::A_STAT)
				next_s.prdata = stat;
			else
			begin
				next_s.prdata = 32'h0;
				next_s.pslverr = 1'b1;
			end
		end

		if (wr)
		begin
			if (apb.paddr == gsz_pkg::A_CTRL)
			begin
				next_s.filt_k = apb.pwdata[gsz_pkg::C_FILT +: 3];
				// Code 3 is not a mode and is ignored
				if (apb.pwdata[gsz_pkg::C_MODE +: 2] != 2'h3)
					next_s.mode = gsz_pkg::gsz_mode_t'(apb.pwdata[gsz_pkg::C_MODE +: 2]);
				if (apb.pwdata[gsz_pkg::C_MODE +: 2] == 2'h1 || apb.pwdata[gsz_pkg::C_MODE +: 2] == 2'h2)
					next_s.nv_mode = gsz_pkg::gsz_mode_t'(apb.pwdata[gsz_pkg::C_MODE +: 2]);
			end
			else if (apb.paddr == gsz_pkg::A_CMD)
			begin
				if (s.mode == gsz_pkg::M_CMD)
					next_s.refused = next_s.refused | (apb.pwdata[3:0] != 4'h0);
				else
					next_s.pend = next_s.pend | apb.pwdata[3:0];
			end
			else if (apb.paddr == gsz_pkg::A_KNOWN)
				next_s.known = apb.pwdata[15:0];
			else if (apb.paddr == gsz_pkg::A_FRESH)
				next_s.fresh = (apb.pwdata[15:0] > FULL_SCALE) ? FULL_SCALE : apb.pwdata[15:0];
			else if (apb.paddr == gsz_pkg::A_FTRUE)
				next_s.ftrue = apb.pwdata[15:0];
			else if (apb.paddr == gsz_pkg::A_FREP)
				next_s.frep = apb.pwdata[15:0];
			else if (apb.paddr == gsz_pkg::A_STAT && apb.pwdata[gsz_pkg::S_REFUSED])
				next_s.refused = 1'b0;
		end
		// A refusal in the same cycle as its clear still shows
		if (wr && apb.paddr == gsz_pkg::A_CMD && s.mode == gsz_pkg::M_CMD && apb.pwdata[3:0] != 4'h0)
			next_s.refused = 1'b1;

		next_s.rx_s1 = rx_pin;
		next_s.rx_s2 = s.rx_s1;
		next_s.rx_got = 1'b0;
		next_s.rx_cnt = (s.rx_cnt != 12'h0) ? s.rx_cnt - 12'h1 : 12'h0;
		case (s.rx_st)
			gsz_pkg::RX_IDLE:
				if (!s.rx_s2)
				begin
					next_s.rx_st = gsz_pkg::RX_START;
					next_s.rx_cnt = gsz_pkg::HALF_CYC - 12'h1;
				end
			gsz_pkg::RX_START:
				if (s.rx_cnt == 12'h0)
				begin
					next_s.rx_st = s.rx_s2 ? gsz_pkg::RX_IDLE : gsz_pkg::RX_DATA;
					next_s.rx_cnt = gsz_pkg::BIT_CYC - 12'h1;
					next_s.rx_bit = 3'h0;
				end
			gsz_pkg::RX_DATA:
				if (s.rx_cnt == 12'h0)
				begin
					next_s.rx_sh = {s.rx_s2, s.rx_sh[7:1]};
					next_s.rx_cnt = gsz_pkg::BIT_CYC - 12'h1;
					next_s.rx_bit = s.rx_bit + 3'h1;
					if (s.rx_bit == 3'h7)
						next_s.rx_st = gsz_pkg::RX_STOP;
				end
			gsz_pkg::RX_STOP:
				if (s.rx_cnt == 12'h0)
				begin
					next_s.rx_st = gsz_pkg::RX_IDLE;
					// Bad stop bit drops the character
					next_s.rx_got = s.rx_s2;
					if (s.rx_s2)
						next_s.rx_last = s.rx_sh;
				end
			default: next_s.rx_st = gsz_pkg::RX_IDLE;
		endcase

		case (s.tx_st)
			gsz_pkg::TX_IDLE:
			begin
				next_s.tx = 1'b1;
				if (s.send_req)
				begin
					next_s.val = s.filt;
					next_s.qmark = s.send_q;
					next_s.idx = 3'h0;
					next_s.send_req = 1'b0;
					next_s.tx_st = gsz_pkg::TX_LOAD;
				end
			end
			gsz_pkg::TX_LOAD:
			begin
				next_s.tx_sh = {1'b1, ch, 1'b0};
				if (s.idx != 3'h0 && s.idx <= 3'h5 && !s.qmark)
					next_s.val = s.val - 16'(dg * p);
				next_s.tx_bit = 4'h0;
				next_s.tx_cnt = gsz_pkg::BIT_CYC - 12'h1;
				next_s.tx_st = gsz_pkg::TX_BIT;
			end
			gsz_pkg::TX_BIT:
			begin
				next_s.tx = s.tx_sh[0];
				next_s.tx_cnt = s.tx_cnt - 12'h1;
				if (s.tx_cnt == 12'h0)
				begin
					next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
					next_s.tx_cnt = gsz_pkg::BIT_CYC - 12'h1;
					next_s.tx_bit = s.tx_bit + 4'h1;
					if (s.tx_bit == 4'h9)
					begin
						next_s.idx = (s.qmark && s.idx == 3'h1) ? 3'h6 : s.idx + 3'h1;
						next_s.tx_st = (s.idx == 3'h7) ? gsz_pkg::TX_IDLE : gsz_pkg::TX_LOAD;
					end
				end
			end
			default: next_s.tx_st = gsz_pkg::TX_IDLE;
		endcase

		if (meas_now && s.loaded && s.mode == gsz_pkg::M_STREAM)
		begin
			next_s.send_req = 1'b1;
			next_s.send_q = 1'b0;
		end
		// any character with a good stop bit asks for a reading
		if (s.rx_got)
		begin
			next_s.send_req = 1'b1;
			next_s.send_q = (s.mode == gsz_pkg::M_CMD);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
			s.mode <= gsz_pkg::M_STREAM;
			s.nv_mode <= gsz_pkg::M_STREAM;
			s.fresh <= gsz_pkg::FRESH_RST;
			s.rx_s1 <= 1'b1;
			s.rx_s2 <= 1'b1;
			s.rx_st <= gsz_pkg::RX_IDLE;
			s.tx_st <= gsz_pkg::TX_IDLE;
			s.tx <= 1'b1;
		end
		else if (pclk_en)
			s <= next_s;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence stream_meas;
		pclk_en && meas_now && s.loaded && s.mode == gsz_pkg::M_STREAM && !s.rx_got;
	endsequence

	no_sleep_meas_a: assert property (pclk_en && meas_now && s.mode == gsz_pkg::M_CMD |=> $stable(s.filt) && $stable(s.conc)) else $error("reading taken in sleep mode");
	refuse_cal_a: assert property (pclk_en && wr && apb.paddr == gsz_pkg::A_CMD && apb.pwdata[3:0] != 4'h0 && s.mode == gsz_pkg::M_CMD |=> s.refused && s.pend == 4'h0 && $stable(s.zero)) else $error("calibration not refused in sleep");
	boot_mode_a: assert property (pclk_en && !s.loaded |=> s.loaded && s.mode != gsz_pkg::M_CMD) else $error("boot left device asleep");
	stream_send_a: assert property (stream_meas |=> s.send_req && !s.send_q) else $error("streaming reading not queued");
	hold_off_a: assert property (s.busy <= BUSY_W) else $error("command hold-off too long");
	poll_quiet_a: assert property (pclk_en && s.mode == gsz_pkg::M_POLL && s.tx_st == gsz_pkg::TX_IDLE && !s.send_req && !s.rx_got |=> s.tx_st == gsz_pkg::TX_IDLE) else $error("unsolicited output in polling");
	nitro_zero_a: assert property (pclk_en && exec[gsz_pkg::K_N2] |=> s.zero == $past(sensor_raw)) else $error("nitrogen zero wrong");
	fine_zero_a: assert property (pclk_en && exec[gsz_pkg::K_FINE] |=> s.zero == 16'($past(s.zero) + $past(s.frep) - $past(s.ftrue))) else $error("fine adjust wrong");
	space_first_a: assert property (pclk_en && s.tx_st == gsz_pkg::TX_LOAD && s.idx == 3'h0 |=> s.tx_sh[8:1] == gsz_pkg::CH_SP) else $error("reply lacks leading space");
	rx_reply_a: assert property (pclk_en && s.rx_got |=> s.send_req) else $error("character not answered");

endmodule

`default_nettype wire

// >>> hw/gsz_pkg.sv
/*
 * Shared constants and types for the gas sensor mode and zero control block.
 * Assumes a 25 MHz APB clock; nonvolatile storage sits outside the block.
 */
package gsz_pkg;

	localparam int CLK_HZ = 25_000_000;
	localparam int BAUD = 9600;
	localparam logic [11:0] BIT_CYC = 12'(CLK_HZ / BAUD);
	localparam logic [11:0] HALF_CYC = 12'(CLK_HZ / BAUD / 2);
	localparam int MEAS_MS = 500;
	localparam int MEAS_CYC = CLK_HZ / 1000 * MEAS_MS;
	localparam int POSTPONE_MS = 10;
	localparam int POSTPONE_CYC = CLK_HZ / 1000 * POSTPONE_MS;

	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_KNOWN = 8'h08;
	localparam logic [7:0] A_FRESH = 8'h0c;
	localparam logic [7:0] A_FTRUE = 8'h10;
	localparam logic [7:0] A_FREP = 8'h14;
	localparam logic [7:0] A_ZERO = 8'h18;
	localparam logic [7:0] A_FILT = 8'h1c;
	localparam logic [7:0] A_RAW = 8'h20;
	localparam logic [7:0] A_STAT = 8'h24;

	localparam int C_MODE = 0;
	localparam int C_FILT = 2;
	localparam int K_KNOWN = 0;
	localparam int K_N2 = 1;
	localparam int K_FRESH = 2;
	localparam int K_FINE = 3;
	localparam int S_READY = 0;
	localparam int S_REFUSED = 1;
	localparam int S_BUSY = 2;
	localparam int S_RXB = 8;

	localparam logic [15:0] FRESH_RST = 16'h0190;
	localparam logic [15:0] FULL_PPM = 16'h2710;

	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_QM = 8'h3f;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_0 = 8'h30;

	typedef enum logic [1:0] {M_CMD = 2'h0, M_STREAM = 2'h1, M_POLL = 2'h2} gsz_mode_t;
	typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_LOAD = 3'b010, TX_BIT = 3'b100} gsz_tx_t;
	typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100,
		RX_STOP = 4'b1000} gsz_rx_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} gsz_apb_t;

	typedef struct packed {
		logic valid;
		gsz_mode_t mode;
		logic [15:0] zero;
		logic [15:0] fresh;
	} gsz_nv_t;

	typedef struct packed {
		logic loaded;
		gsz_mode_t mode;
		gsz_mode_t nv_mode;
		logic [2:0] filt_k;
		logic [3:0] pend;
		logic refused;
		logic [15:0] known;
		logic [15:0] fresh;
		logic [15:0] ftrue;
		logic [15:0] frep;
		logic [15:0] zero;
		logic [15:0] conc;
		logic [15:0] filt;
		logic [23:0] tick;
		logic [17:0] busy;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic rx_s1;
		logic rx_s2;
		gsz_rx_t rx_st;
		logic [11:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic [7:0] rx_last;
		logic rx_got;
		gsz_tx_t tx_st;
		logic tx;
		logic [9:0] tx_sh;
		logic [11:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [2:0] idx;
		logic qmark;
		logic [15:0] val;
		logic send_req;
		logic send_q;
	} gsz_state_t;

endpackage

// >>> tb/gsz_host_model.sv
/*
 * Host end of the serial link: sends single characters and receives one reply byte.
 * Assumes it is clocked by pclk and that the bench calls its tasks by hierarchical name.
 */
`timescale 1ns/1ns
`default_nettype none

module gsz_host_model (
	input wire logic clk, // bench clock
	input wire logic rx_line, // from device serial out
	output logic tx_line // to device serial in
);
	// Idle level of the link between characters
	initial tx_line = 1'b1;

	task automatic send_char(input logic [7:0] c);
		logic [9:0] f;
		f = {1'b1, c, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk);
			tx_line <= f[i];
			repeat (gsz_pkg::BIT_CYC - 1) @(posedge clk);
		end
	endtask

	// Mid-bit sampling
	// Also starts when the line is already low, so a caller may look for the start bit first
	task automatic recv_char(output logic [7:0] c, output logic stop);
		while (rx_line !== 1'b0) @(posedge clk);
		repeat (gsz_pkg::HALF_CYC) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (gsz_pkg::BIT_CYC) @(posedge clk);
			c[i] = rx_line;
		end
		repeat (gsz_pkg::BIT_CYC) @(posedge clk);
		stop = rx_line;
	endtask
endmodule

`default_nettype wire

// >>> tb/tb.sv
/*
 * Self-checking bench for the mode and zero control block: APB master, serial host, table of register cases.
 * Assumes a short measurement period parameter so that several readings fit into one run.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
	localparam int MP = 200;
	localparam logic [31:0] ZX [4] = '{32'h0f00, 32'h1000, 32'h0e70, 32'h0ec0};
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic [31:0] m;} gsz_row_t;
	logic pclk;
	logic presetn;
	gsz_pkg::gsz_apb_t apb;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] sensor_raw;
	gsz_pkg::gsz_nv_t nv_in;
	gsz_pkg::gsz_nv_t nv_out;
	logic rx_pin;
	logic tx_pin;
	logic ready;
	logic [15:0] conc_out;
	logic [15:0] raw_out;
	logic tx_low;
	int bad_count;
	int n_checks;
	gsz_row_t rows [11];

	gsz_ctrl #(.MEAS_PERIOD(MP), .MEAS_BUSY(20), .FULL_SCALE(16'h2710)) i_gsz_ctrl (.pclk(pclk),
		.presetn(presetn), .pclk_en(1'b1), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sensor_raw(sensor_raw), .nv_in(nv_in), .nv_out(nv_out), .rx_pin(rx_pin), .tx_pin(tx_pin),
		.ready(ready), .conc_out(conc_out), .raw_out(raw_out));
	gsz_host_model i_gsz_host_model (.clk(pclk), .rx_line(tx_pin), .tx_line(rx_pin));

	task automatic results();
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Waits for pready with no limit of its own; the watchdog ends a hang
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb.penable <= 1'b1;
		@(negedge pclk);
		while (pready !== 1'b1) @(negedge pclk);
		r = prdata;
		e = pslverr;
		@(posedge pclk);
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		xfer(1'b1, a, d, r, e);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		xfer(1'b0, a, 32'h0, r, e);
		chk(r & m, x);
	endtask

	always @(negedge pclk)
		if (tx_pin === 1'b0)
			tx_low <= 1'b1;

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	initial
	begin
		#3_600_000;
		bad_count++;
		results();
	end

	initial
	begin
		logic [7:0] c;
		logic s;
		logic [31:0] r;
		logic e;
		int n;
		apb = '0;
		presetn = 1'b0;
		sensor_raw = 16'h1000;
		nv_in = '{1'b1, gsz_pkg::M_POLL, 16'h0000, 16'h0300};
		tx_low = 1'b0;
		bad_count = 0;
		n_checks = 0;
		rows = '{'{1'b0, gsz_pkg::A_CTRL, 32'h0, 32'h2, 32'h1f},
			'{1'b0, gsz_pkg::A_FRESH, 32'h0, 32'h0300, 32'hffff},
			'{1'b1, gsz_pkg::A_FRESH, 32'h3000, 32'h0, 32'h0},
			'{1'b0, gsz_pkg::A_FRESH, 32'h0, 32'h2710, 32'hffff},
			'{1'b1, gsz_pkg::A_FRESH, 32'h0190, 32'h0, 32'h0},
			'{1'b1, gsz_pkg::A_KNOWN, 32'h0100, 32'h0, 32'h0},
			'{1'b0, gsz_pkg::A_KNOWN, 32'h0, 32'h0100, 32'hffff},
			'{1'b1, gsz_pkg::A_FTRUE, 32'h0200, 32'h0, 32'h0},
			'{1'b1, gsz_pkg::A_FREP, 32'h0250, 32'h0, 32'h0},
			'{1'b0, gsz_pkg::A_FREP, 32'h0, 32'h0250, 32'hffff},
			'{1'b0, gsz_pkg::A_STAT, 32'h0, 32'h1, 32'h1}};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		foreach (rows[i])
		begin
			xfer(rows[i].w, rows[i].a, rows[i].d, r, e);
			if (!rows[i].w)
				chk(r & rows[i].m, rows[i].x);
		end
		// Unmapped address answers with an error and zero data
		xfer(1'b0, 8'h28, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1);
		chk(32'(ready), 32'h1);
		for (int k = 0; k < 4; k++)
		begin
			wr(gsz_pkg::A_CMD, 32'h1 << k);
			n = 0;
			do xfer(1'b0, gsz_pkg::A_CMD, 32'h0, r, e); while (r[3:0] !== 4'h0 && n++ < 40);
			rdc(gsz_pkg::A_ZERO, 32'hffff, ZX[k]);
		end
		chk(32'(nv_out.zero), 32'h0ec0);
		repeat (2 * MP + 5) @(posedge pclk);
		chk(32'(raw_out), 32'h0140);
		chk(32'(conc_out), 32'h0140);
		wr(gsz_pkg::A_CTRL, 32'h6);
		sensor_raw <= 16'h1100;
		n = 0;
		while (raw_out !== 16'h0240 && n++ < MP + 10) @(negedge pclk);
		repeat (3) @(negedge pclk);
		chk(32'(conc_out), 32'h01c0);
		repeat (2) rdc(gsz_pkg::A_FILT, 32'hffff, 32'h01c0);
		chk(32'(tx_low), 32'h0);
		fork
			i_gsz_host_model.send_char(8'h41);
			i_gsz_host_model.recv_char(c, s);
		join
		chk({23'h0, s, c}, {23'h0, 1'b1, gsz_pkg::CH_SP});
		rdc(gsz_pkg::A_STAT, 32'hff00, 32'h4100);
		// Sleep mode: calibration refused, readings frozen
		wr(gsz_pkg::A_CTRL, 32'h0);
		sensor_raw <= 16'h1200;
		wr(gsz_pkg::A_CMD, 32'h2);
		repeat (2 * MP) @(posedge pclk);
		rdc(gsz_pkg::A_ZERO, 32'hffff, 32'h0ec0);
		rdc(gsz_pkg::A_STAT, 32'h2, 32'h2);
		chk(32'(raw_out), 32'h0240);
		chk(32'(nv_out.mode), 32'h2);
		wr(gsz_pkg::A_STAT, 32'h2);
		rdc(gsz_pkg::A_STAT, 32'h2, 32'h0);
		// Power cycle from sleep with empty storage comes up streaming
		nv_in <= '{1'b0, gsz_pkg::M_POLL, 16'h1234, 16'h0300};
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(32'(ready), 32'h0);
		presetn <= 1'b1;
		n = 0;
		while (tx_pin !== 1'b0 && n++ < MP + 20) @(negedge pclk);
		chk(32'(tx_pin), 32'h0);
		i_gsz_host_model.recv_char(c, s);
		chk({23'h0, s, c}, {23'h0, 1'b1, gsz_pkg::CH_SP});
		rdc(gsz_pkg::A_CTRL, 32'h3, 32'h1);
		rdc(gsz_pkg::A_FRESH, 32'hffff, 32'h0190);
		rdc(gsz_pkg::A_ZERO, 32'hffff, 32'h0);
		// Mode code 3 is ignored, filter field still written
		wr(gsz_pkg::A_CTRL, 32'h7);
		rdc(gsz_pkg::A_CTRL, 32'h1f, 32'h5);
		results();
	end
endmodule

`default_nettype wire
